/* File: rtl/rtx_pkg.sv */
// constants, modes and carrier types of the radio command sequencer
// assumes one device top on a 10 MHz system clock and an SPI mode-0 link clock
// How it works
// (R1) calibrate after reset, then standby, busy low
// (R2) host enters standby before configuring radio
// (R3) host follows the fixed transmit command order
// (R4) host routes transmit-done to exactly one pin
// (R5) after transmit, return to standby; host clears flag
// (R6) host follows the fixed receive command order
// (R7) continuous receive stays; single receive returns standby
// (R8) host checks crc flag before accepting packet
// (R9) host clears flags, reads buffer info, payload
// (R10) protocol, then modulation, then frame format first
// (R11) host fixes bandwidth bit before each transmit
// (R12) host ORs clamp bits after cold start
// (R13) implicit-header css receive keeps timeout timer running
// (R14) host stops timer and clears stale timeout
// (R15) busy pin shows processing; host waits low
package rtx_pkg;
    // opcodes
    localparam logic [7:0] OP_STANDBY  = 8'h20;
    localparam logic [7:0] OP_PROTOCOL = 8'h21;
    localparam logic [7:0] OP_FREQ     = 8'h22;
    localparam logic [7:0] OP_AMP      = 8'h23;
    localparam logic [7:0] OP_POWER    = 8'h24;
    localparam logic [7:0] OP_BASE     = 8'h25;
    localparam logic [7:0] OP_PAYLOAD  = 8'h26;
    localparam logic [7:0] OP_MOD      = 8'h27;
    localparam logic [7:0] OP_FORMAT   = 8'h28;
    localparam logic [7:0] OP_PINMAP   = 8'h29;
    localparam logic [7:0] OP_WREG     = 8'h2A;
    localparam logic [7:0] OP_RREG     = 8'h2B;
    localparam logic [7:0] OP_TX       = 8'h2C;
    localparam logic [7:0] OP_RX       = 8'h2D;
    localparam logic [7:0] OP_RDFLAGS  = 8'h2E;
    localparam logic [7:0] OP_CLRFLAGS = 8'h2F;
    localparam logic [7:0] OP_BUFINFO  = 8'h13;
    // register addresses and reset values
    localparam logic [15:0] ADDR_BW_FIX   = 16'h0889;
    localparam logic [15:0] ADDR_CLAMP    = 16'h08D8;
    localparam logic [15:0] ADDR_TMR_STOP = 16'h0920;
    localparam logic [15:0] ADDR_EVT_CLR  = 16'h0944;
    localparam logic [7:0]  RST_BW_FIX    = 8'h00;
    localparam logic [7:0]  RST_CLAMP     = 8'h08;
    localparam logic [7:0]  RST_TMR_STOP  = 8'h00;
    localparam logic [7:0]  RST_EVT_CLR   = 8'h00;
    localparam logic [7:0]  EVT_CLR_MASK  = 8'h02;
    // event flag bit positions
    localparam int FLG_TX_DONE = 0;
    localparam int FLG_RX_DONE = 1;
    localparam int FLG_CRC_ERR = 6;
    localparam int FLG_TIMEOUT = 9;
    // mode codes in the status byte
    localparam logic [2:0] MCODE_CAL  = 3'h0;
    localparam logic [2:0] MCODE_STBY = 3'h2;
    localparam logic [2:0] MCODE_RX   = 3'h5;
    localparam logic [2:0] MCODE_TX   = 3'h6;
    // timing and sizes
    localparam logic [7:0]  CAL_CYC     = 8'h32;
    localparam logic [1:0]  PROC_CYC    = 2'h2;
    localparam int          FRAME_BYTES = 9;
    localparam logic [23:0] TMR_CONT    = 24'hFFFFFF;

    typedef enum logic [1:0] {RTX_CAL, RTX_STBY, RTX_TX, RTX_RX} rtx_mode_t;

    typedef struct packed {
        logic [7:0]  status;
        logic [15:0] flags;
        logic [7:0]  rx_len;
        logic [7:0]  rx_ptr;
        logic [7:0]  bw_fix;
        logic [7:0]  clamp;
        logic [7:0]  tmr_stop;
        logic [7:0]  evt_clr;
    } rtx_snap_t;

    typedef struct packed {
        logic [7:0] bw_fix;
        logic [7:0] clamp;
        logic       css;
        logic       implicit_hdr;
    } rtx_rfcfg_t;
endpackage

/* File: rtl/rtx_radio_txrx_config_sequencer.sv */
// device side of the radio command sequencer: spi frame capture and command execution
// assumes spi mode 0, host keeps nss low 400 ns before the first sck edge and honours busy
`timescale 1ns/1ns
module rtx_radio_txrx_config_sequencer
(
    // system
    input  wire logic                 clock_i,
    input  wire logic                 rst_b_i,
    // spi link
    input  wire logic                 spi_sck_i,
    input  wire logic                 spi_nss_b_i,
    input  wire logic                 spi_mosi_i,
    output logic                      spi_miso_o,
    output logic                      spi_miso_oe_b_o,
    // status pins
    output logic                      busy_o,
    output logic [2:0]                event_pin_o,
    // radio core
    input  wire logic                 rf_tx_done_i,
    input  wire logic                 rf_rx_pkt_i,
    input  wire logic                 rf_crc_ok_i,
    input  wire logic [7:0]           rf_rx_len_i,
    output rtx_pkg::rtx_mode_t        mode_o,
    output rtx_pkg::rtx_rfcfg_t       rf_cfg_o
);
    ////////////////////////////////////////////////////////////////////////////
    // link domain: frame capture and reply shifting
    logic [7:0]          frame_q [rtx_pkg::FRAME_BYTES];
    logic [6:0]          pos_q;
    logic [6:0]          shift_q;
    logic                miso_q;
    logic                frame_rst_b;
    rtx_pkg::rtx_snap_t  snap_q;
    logic [7:0]          reply_byte;
    logic [3:0]          byte_idx;

    // bit counter restarts with every frame, so nss acts as its reset
    assign frame_rst_b = rst_b_i & ~spi_nss_b_i;
    assign byte_idx    = pos_q[6:3];

    always_ff @(posedge spi_sck_i or negedge frame_rst_b)
    begin
        if (!frame_rst_b)
        begin
            pos_q   <= 7'h00;
            shift_q <= 7'h00;
        end
        else
        begin
            shift_q <= {shift_q[5:0], spi_mosi_i};
            if (pos_q != 7'h7F)
                pos_q <= pos_q + 7'h01;
        end
    end

    // frame bytes stay put once nss rises; the system side reads them then
    always_ff @(posedge spi_sck_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
        begin
            for (int i = 0; i < rtx_pkg::FRAME_BYTES; i++)
                frame_q[i] <= 8'h00;
        end
        else if (pos_q[2:0] == 3'h7 && 32'(byte_idx) < rtx_pkg::FRAME_BYTES)
        begin
            frame_q[byte_idx] <= {shift_q, spi_mosi_i};
        end
    end

    // snap_q is frozen while nss is low, so it crosses as a quasi-static word
    always_comb
    begin
        reply_byte = snap_q.status;
        if (byte_idx == 4'h0)
            reply_byte = 8'h00;
        else if (frame_q[0] == rtx_pkg::OP_RDFLAGS && byte_idx == 4'h2)
            reply_byte = snap_q.flags[15:8];
        else if (frame_q[0] == rtx_pkg::OP_RDFLAGS && byte_idx == 4'h3)
            reply_byte = snap_q.flags[7:0];
        else if (frame_q[0] == rtx_pkg::OP_BUFINFO && byte_idx == 4'h2)
            reply_byte = snap_q.rx_len;
        else if (frame_q[0] == rtx_pkg::OP_BUFINFO && byte_idx == 4'h3)
            reply_byte = snap_q.rx_ptr;
        else if (frame_q[0] == rtx_pkg::OP_RREG && byte_idx >= 4'h4)
        begin
            case ({frame_q[1], frame_q[2]})
                rtx_pkg::ADDR_BW_FIX:   reply_byte = snap_q.bw_fix;
                rtx_pkg::ADDR_CLAMP:    reply_byte = snap_q.clamp;
                rtx_pkg::ADDR_TMR_STOP: reply_byte = snap_q.tmr_stop;
                rtx_pkg::ADDR_EVT_CLR:  reply_byte = snap_q.evt_clr;
                default:                reply_byte = 8'h00;
            endcase
        end
    end

    always_ff @(negedge spi_sck_i or negedge frame_rst_b)
    begin
        if (!frame_rst_b)
            miso_q <= 1'b0;
        else
            miso_q <= reply_byte[3'h7 - pos_q[2:0]];
    end

    assign spi_miso_o      = miso_q;
    assign spi_miso_oe_b_o = spi_nss_b_i;

    ////////////////////////////////////////////////////////////////////////////
    // system domain: nss synchroniser and command decode
    logic        nss_meta_q;
    logic        nss_sync_q;
    logic        nss_prev_q;
    logic        exec;
    logic [7:0]  op;
    logic [15:0] addr;
    logic [23:0] tparam;
    logic        wreg;

    always_ff @(posedge clock_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
        begin
            nss_meta_q <= 1'b1;
            nss_sync_q <= 1'b1;
            nss_prev_q <= 1'b1;
        end
        else
        begin
            nss_meta_q <= spi_nss_b_i;
            nss_sync_q <= nss_meta_q;
            nss_prev_q <= nss_sync_q;
        end
    end

    assign exec   = nss_sync_q & ~nss_prev_q;
    assign op     = frame_q[0];
    assign addr   = {frame_q[1], frame_q[2]};
    assign tparam = {frame_q[1], frame_q[2], frame_q[3]};
    assign wreg   = exec && op == rtx_pkg::OP_WREG;

    ////////////////////////////////////////////////////////////////////////////
    // registers and configuration
    logic [7:0]  bw_fix_q;
    logic [7:0]  clamp_q;
    logic [7:0]  tmr_stop_q;
    logic [7:0]  evt_clr_q;
    logic        css_q;
    logic        implicit_q;
    logic [15:0] irq_en_q;
    logic [15:0] pin_mask_q [3];
    logic [7:0]  rx_base_q;
    logic        stop_wr;
    logic        evt_clr_wr;

    assign stop_wr    = wreg && addr == rtx_pkg::ADDR_TMR_STOP && frame_q[3] == 8'h00;
    assign evt_clr_wr = wreg && addr == rtx_pkg::ADDR_EVT_CLR && (frame_q[3] & rtx_pkg::EVT_CLR_MASK) != 8'h00;

    always_ff @(posedge clock_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
        begin
            bw_fix_q   <= rtx_pkg::RST_BW_FIX;
            clamp_q    <= rtx_pkg::RST_CLAMP;
            tmr_stop_q <= rtx_pkg::RST_TMR_STOP;
            evt_clr_q  <= rtx_pkg::RST_EVT_CLR;
        end
        else if (wreg)
        begin
            case (addr)
                rtx_pkg::ADDR_BW_FIX:   bw_fix_q   <= frame_q[3];
                rtx_pkg::ADDR_CLAMP:    clamp_q    <= frame_q[3];
                rtx_pkg::ADDR_TMR_STOP: tmr_stop_q <= frame_q[3];
                // the clear bit acts once and reads back as zero
                rtx_pkg::ADDR_EVT_CLR:  evt_clr_q  <= frame_q[3] & ~rtx_pkg::EVT_CLR_MASK;
                default:                tmr_stop_q <= tmr_stop_q;
            endcase
        end
    end

    always_ff @(posedge clock_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
        begin
            css_q      <= 1'b0;
            implicit_q <= 1'b0;
            irq_en_q   <= 16'h0000;
            rx_base_q  <= 8'h00;
            for (int k = 0; k < 3; k++)
                pin_mask_q[k] <= 16'h0000;
        end
        else if (exec)
        begin
            if (op == rtx_pkg::OP_PROTOCOL)
                css_q <= frame_q[1][0];
            if (op == rtx_pkg::OP_FORMAT)
                implicit_q <= frame_q[1][0];
            if (op == rtx_pkg::OP_BASE)
                rx_base_q <= frame_q[2];
            if (op == rtx_pkg::OP_PINMAP)
            begin
                irq_en_q <= {frame_q[1], frame_q[2]};
                for (int k = 0; k < 3; k++)
                    pin_mask_q[k] <= {frame_q[2 * k + 3], frame_q[2 * k + 4]};
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // operating mode, timeout timer and event flags
    rtx_pkg::rtx_mode_t mode_q;
    logic [7:0]  cal_cnt_q;
    logic        cont_q;
    logic [23:0] tmr_q;
    logic        tmr_run_q;
    logic        timeout;
    logic        tx_done;
    logic        rx_pkt;
    logic [15:0] flags_q;
    logic [15:0] flag_set;
    logic [15:0] flag_clr;
    logic        start_tx;
    logic        start_rx;

    assign start_tx = exec && op == rtx_pkg::OP_TX;
    assign start_rx = exec && op == rtx_pkg::OP_RX;
    assign timeout  = tmr_run_q && tmr_q == 24'h000001;
    assign tx_done  = mode_q == rtx_pkg::RTX_TX && rf_tx_done_i;
    assign rx_pkt   = mode_q == rtx_pkg::RTX_RX && rf_rx_pkt_i;

    always_ff @(posedge clock_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
        begin
            mode_q    <= rtx_pkg::RTX_CAL;
            cal_cnt_q <= rtx_pkg::CAL_CYC;
            cont_q    <= 1'b0;
        end
        else
        begin
            case (mode_q)
                rtx_pkg::RTX_CAL:
                begin
                    cal_cnt_q <= cal_cnt_q - 8'h01;
                    if (cal_cnt_q == 8'h01)
                        mode_q <= rtx_pkg::RTX_STBY; // [R1]
                end
                rtx_pkg::RTX_TX:
                    if (tx_done || timeout)
                        mode_q <= rtx_pkg::RTX_STBY; // [R5]
                rtx_pkg::RTX_RX:
                    if ((rx_pkt && !cont_q) || timeout)
                        mode_q <= rtx_pkg::RTX_STBY; // [R7]
                default:
                    mode_q <= mode_q;
            endcase
            if (mode_q != rtx_pkg::RTX_CAL)
            begin
                if (exec && op == rtx_pkg::OP_STANDBY)
                    mode_q <= rtx_pkg::RTX_STBY;
                if (start_tx)
                    mode_q <= rtx_pkg::RTX_TX;
                if (start_rx)
                begin
                    mode_q <= rtx_pkg::RTX_RX;
                    cont_q <= tparam == rtx_pkg::TMR_CONT;
                end
            end
        end
    end

    always_ff @(posedge clock_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
        begin
            tmr_q     <= 24'h000000;
            tmr_run_q <= 1'b0;
        end
        else if ((start_tx || start_rx) && mode_q != rtx_pkg::RTX_CAL)
        begin
            tmr_q     <= tparam;
            tmr_run_q <= tparam != 24'h000000 && tparam != rtx_pkg::TMR_CONT;
        end
        else if (stop_wr || timeout || tx_done || (rx_pkt && !(css_q && implicit_q)))
        begin
            // implicit-header css receive leaves the timer running [R13]
            tmr_run_q <= 1'b0;
        end
        else if (tmr_run_q)
        begin
            tmr_q <= tmr_q - 24'h000001;
        end
    end

    always_comb
    begin
        flag_set = 16'h0000;
        flag_set[rtx_pkg::FLG_TX_DONE] = tx_done; // [R5]
        flag_set[rtx_pkg::FLG_RX_DONE] = rx_pkt;
        flag_set[rtx_pkg::FLG_CRC_ERR] = rx_pkt && !rf_crc_ok_i;
        flag_set[rtx_pkg::FLG_TIMEOUT] = timeout;
        flag_clr = 16'h0000;
        if (exec && op == rtx_pkg::OP_CLRFLAGS)
            flag_clr = {frame_q[1], frame_q[2]};
        if (evt_clr_wr)
            flag_clr[rtx_pkg::FLG_TIMEOUT] = 1'b1;
    end

    // a new event beats a clear in the same cycle
    always_ff @(posedge clock_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
            flags_q <= 16'h0000;
        else
            flags_q <= (flags_q & ~flag_clr) | flag_set;
    end

    ////////////////////////////////////////////////////////////////////////////
    // receive buffer info, pins, busy and reply snapshot
    logic [7:0] rx_len_q;
    logic [7:0] rx_ptr_q;
    logic [2:0] evt_pin_q;
    logic       busy_q;
    logic [1:0] proc_cnt_q;
    logic [2:0] mcode;

    always_ff @(posedge clock_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
        begin
            rx_len_q <= 8'h00;
            rx_ptr_q <= 8'h00;
        end
        else if (rx_pkt)
        begin
            rx_len_q <= rf_rx_len_i;
            rx_ptr_q <= rx_base_q;
        end
    end

    always_ff @(posedge clock_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
            evt_pin_q <= 3'h0;
        else
            for (int k = 0; k < 3; k++)
                evt_pin_q[k] <= |(flags_q & irq_en_q & pin_mask_q[k]);
    end

    // busy covers calibration, a selected frame and the execution after it
    always_ff @(posedge clock_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
        begin
            busy_q     <= 1'b1;
            proc_cnt_q <= 2'h0;
        end
        else
        begin
            proc_cnt_q <= exec ? rtx_pkg::PROC_CYC : (proc_cnt_q != 2'h0 ? proc_cnt_q - 2'h1 : 2'h0);
            busy_q     <= mode_q == rtx_pkg::RTX_CAL || !nss_sync_q || exec || proc_cnt_q > 2'h1; // [R15] [R1]
        end
    end

    always_comb
    begin
        case (mode_q)
            rtx_pkg::RTX_STBY: mcode = rtx_pkg::MCODE_STBY;
            rtx_pkg::RTX_TX:   mcode = rtx_pkg::MCODE_TX;
            rtx_pkg::RTX_RX:   mcode = rtx_pkg::MCODE_RX;
            default:           mcode = rtx_pkg::MCODE_CAL;
        endcase
    end

    always_ff @(posedge clock_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
            snap_q <= '0;
        else if (nss_sync_q)
            snap_q <= {1'b0, mcode, 4'h0, flags_q, rx_len_q, rx_ptr_q, bw_fix_q, clamp_q, tmr_stop_q, evt_clr_q};
    end

    assign busy_o      = busy_q;
    assign event_pin_o = evt_pin_q;
    assign mode_o      = mode_q;
    assign rf_cfg_o    = '{bw_fix: bw_fix_q, clamp: clamp_q, css: css_q, implicit_hdr: implicit_q};

    ////////////////////////////////////////////////////////////////////////////
    // checks
    default clocking cb @(posedge clock_i); endclocking
    default disable iff (!rst_b_i);

    a_cal_busy_high: assert property (mode_q == rtx_pkg::RTX_CAL |=> busy_q) // [R1]
        else $error("busy low during calibration");
    a_cal_ends_stby: assert property ($past(mode_q) == rtx_pkg::RTX_CAL && mode_q != rtx_pkg::RTX_CAL
                                      |-> mode_q == rtx_pkg::RTX_STBY) // [R1]
        else $error("calibration did not end in standby");
    a_tx_done_stby: assert property (tx_done && !exec |=> mode_q == rtx_pkg::RTX_STBY
                                     && flags_q[rtx_pkg::FLG_TX_DONE]) // [R5]
        else $error("transmit end did not reach standby with flag");
    a_rx_cont_stays: assert property (rx_pkt && cont_q && !timeout && !exec |=> mode_q == rtx_pkg::RTX_RX) // [R7]
        else $error("continuous receive left receive");
    a_rx_single_stby: assert property (rx_pkt && !cont_q && !exec |=> mode_q == rtx_pkg::RTX_STBY) // [R7]
        else $error("single receive did not return to standby");
    a_implicit_tmr_on: assert property (rx_pkt && css_q && implicit_q && tmr_run_q && !timeout && !exec && !stop_wr
                                        |=> tmr_run_q) // [R13]
        else $error("implicit header receive stopped the timer");
    a_frame_busy: assert property ($fell(nss_sync_q) |-> ##1 busy_q [*3]) // [R15]
        else $error("busy not high while a frame is handled");
    a_busy_release: assert property ($rose(nss_sync_q) && mode_q != rtx_pkg::RTX_CAL
                                     |-> ##[1:4] !busy_q) // [R15]
        else $error("busy did not fall after command");
    a_set_beats_clr: assert property (timeout |=> flags_q[rtx_pkg::FLG_TIMEOUT]) // [R13]
        else $error("timeout lost to a clear");
    a_stop_reg_halts: assert property (stop_wr |=> !tmr_run_q && $stable(tmr_q))
        else $error("timer kept running after stop write");

    c_tx_done: cover property (tx_done ##[1:60] exec && op == rtx_pkg::OP_CLRFLAGS);
    c_spurious_tmo: cover property (rx_pkt && implicit_q && css_q ##[1:200] timeout && mode_q == rtx_pkg::RTX_STBY);
    c_rx_cont: cover property (rx_pkt && cont_q ##[1:200] rx_pkt);
endmodule // rtx_radio_txrx_config_sequencer

/* File: sim/rtx_host_model.sv */
// spi host model: frames opcode commands into the sequencer
// assumes spi mode 0, a 15 ns link clock that stands low outside frames
`timescale 1ns/1ns
module rtx_host_model
(
    // system
    input  wire logic clock_i,
    input  wire logic busy_i,
    // spi link
    input  wire logic spi_miso_i,
    output logic      spi_sck_o,
    output logic      spi_nss_b_o,
    output logic      spi_mosi_o
);
    initial
    begin
        spi_sck_o   = 1'b0;
        spi_nss_b_o = 1'b1;
        spi_mosi_o  = 1'b0;
    end

    ////////////////////////////////////////////////////////////////
    // n whole bytes of tx, msb first, left aligned; reply likewise
    task automatic xfer(input logic [71:0] tx, input int n, output logic [71:0] rx);
        int k;
        rx = '0;
        k  = 0;
        while (busy_i !== 1'b0 && k < 300)
        begin
            @(negedge clock_i);
            k++;
        end
        spi_nss_b_o = 1'b0;
        #400;
        for (int i = 0; i < n * 8; i++)
        begin
            spi_mosi_o = tx[71-i];
            #7 spi_sck_o = 1'b1;
            rx[71-i] = spi_miso_i;
            #8 spi_sck_o = 1'b0;
        end
        #8;
        // released line must not keep showing the last bit
        spi_mosi_o  = ~spi_mosi_o;
        spi_nss_b_o = 1'b1;
        #400;
        k = 0;
        while (busy_i !== 1'b0 && k < 50)
        begin
            @(negedge clock_i);
            k++;
        end
    endtask
endmodule // rtx_host_model

/* File: sim/testbench.sv */
// self-checking bench for the radio command sequencer
// assumes the host model owns the spi link; the bench drives the radio core
`timescale 1ns/1ns
module testbench;
    logic                clock_i;
    logic                rst_b_i;
    logic                tx_done;
    logic                rx_pkt;
    logic                crc_ok;
    logic [7:0]          rx_len;
    logic                sck;
    logic                nss_b;
    logic                mosi;
    logic                miso;
    logic                busy;
    logic [2:0]          evt;
    logic                miso_oe_b;
    rtx_pkg::rtx_mode_t  mode;
    rtx_pkg::rtx_rfcfg_t cfg;
    logic [71:0]         rep;
    logic [15:0]         f;
    logic [7:0]          d;
    int                  error_cnt = 0;
    int                  samples_checked = 0;

    rtx_radio_txrx_config_sequencer rtx_radio_txrx_config_sequencer_inst
    (
        .clock_i         (clock_i),
        .rst_b_i         (rst_b_i),
        .spi_sck_i       (sck),
        .spi_nss_b_i     (nss_b),
        .spi_mosi_i      (mosi),
        .spi_miso_o      (miso),
        .spi_miso_oe_b_o (miso_oe_b),
        .busy_o          (busy),
        .event_pin_o     (evt),
        .rf_tx_done_i    (tx_done),
        .rf_rx_pkt_i     (rx_pkt),
        .rf_crc_ok_i     (crc_ok),
        .rf_rx_len_i     (rx_len),
        .mode_o          (mode),
        .rf_cfg_o        (cfg)
    );

    rtx_host_model rtx_host_model_inst
    (
        .clock_i     (clock_i),
        .busy_i      (busy),
        .spi_miso_i  (miso),
        .spi_sck_o   (sck),
        .spi_nss_b_o (nss_b),
        .spi_mosi_o  (mosi)
    );

    initial
    begin
        clock_i = 1'b0;
        forever #50 clock_i = ~clock_i;
    end

    ////////////////////////////////////////////////////////////////
    task automatic chk(input logic [23:0] got, input logic [23:0] exp);
        samples_checked++;
        if (got !== exp)
        begin
            error_cnt++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    // the reply line must be driven at every sampling edge of a frame
    always @(posedge sck) chk(miso_oe_b, 1'b0);
    task automatic cmd(input logic [71:0] b, input int n);
        rtx_host_model_inst.xfer(b, n, rep);
        chk(busy, 1'b0);
    endtask
    task automatic rd_flags;
        cmd({rtx_pkg::OP_RDFLAGS, 64'h0}, 4);
        f = rep[55:40];
    endtask
    task automatic r_reg(input logic [15:0] a);
        cmd({rtx_pkg::OP_RREG, a, 48'h0}, 5);
        d = rep[39:32];
    endtask
    task automatic w_reg(input logic [15:0] a, input logic [7:0] v);
        cmd({rtx_pkg::OP_WREG, a, v, 40'h0}, 4);
    endtask
    task automatic negs(input int n);
        repeat (n) @(negedge clock_i);
    endtask
    task automatic pulse(input logic rx, input logic ok, input logic [7:0] len);
        @(negedge clock_i);
        rx_pkt  = rx;
        tx_done = ~rx;
        crc_ok  = ok;
        rx_len  = len;
        @(negedge clock_i);
        rx_pkt  = 1'b0;
        tx_done = 1'b0;
        negs(3);
    endtask

    ////////////////////////////////////////////////////////////////
    task automatic t_reset;
        int k;
        chk(mode, rtx_pkg::RTX_CAL);
        chk({busy, evt}, 4'h8);
        chk(miso_oe_b, 1'b1);
        chk(cfg, {8'h00, 8'h08, 2'b00});
        rst_b_i = 1'b1;
        k = 0;
        while (busy !== 1'b0 && k < 100)
        begin
            negs(1);
            k++;
        end
        chk(24'(k), rtx_pkg::CAL_CYC + 24'h000001);
        chk(mode, rtx_pkg::RTX_STBY);
    endtask
    task automatic t_regs;
        r_reg(rtx_pkg::ADDR_CLAMP);
        chk(d, 8'h08);
        w_reg(rtx_pkg::ADDR_CLAMP, d | 8'h1E);
        chk(cfg.clamp, 8'h1E);
        r_reg(rtx_pkg::ADDR_CLAMP);
        chk(d, 8'h1E);
        w_reg(16'h0123, 8'h5A);
        r_reg(16'h0123);
        chk(d, 8'h00);
    endtask
    task automatic t_tx;
        cmd({rtx_pkg::OP_STANDBY, 64'h0}, 2);
        cmd({rtx_pkg::OP_PROTOCOL, 8'h01, 56'h0}, 2);
        chk(cfg.css, 1'b1);
        cmd({rtx_pkg::OP_FREQ, 64'h0}, 5);
        cmd({rtx_pkg::OP_AMP, 64'h0}, 5);
        cmd({rtx_pkg::OP_POWER, 64'h0}, 3);
        cmd({rtx_pkg::OP_BASE, 16'h0040, 48'h0}, 3);
        cmd({rtx_pkg::OP_PAYLOAD, 16'h00A5, 48'h0}, 3);
        cmd({rtx_pkg::OP_MOD, 64'h0}, 5);
        cmd({rtx_pkg::OP_FORMAT, 64'h0}, 2);
        cmd({rtx_pkg::OP_PINMAP, 16'h1, 16'h0, 16'h1, 16'h0}, 9);
        w_reg(16'h06C0, 8'h12);
        r_reg(rtx_pkg::ADDR_BW_FIX);
        w_reg(rtx_pkg::ADDR_BW_FIX, d | 8'h04);
        chk(cfg.bw_fix, 8'h04);
        cmd({rtx_pkg::OP_TX, 24'h000400, 40'h0}, 4);
        chk(mode, rtx_pkg::RTX_TX);
        pulse(1'b0, 1'b0, 8'h00);
        chk(mode, rtx_pkg::RTX_STBY);
        chk(evt, 3'b010);
        rd_flags;
        chk({rep[63:56], f}, {1'b0, rtx_pkg::MCODE_STBY, 4'h0, 16'h0001});
        cmd({rtx_pkg::OP_CLRFLAGS, 16'h0001, 48'h0}, 3);
        chk(evt, 3'b000);
    endtask
    task automatic t_rx;
        cmd({rtx_pkg::OP_STANDBY, 64'h0}, 2);
        cmd({rtx_pkg::OP_PROTOCOL, 64'h0}, 2);
        cmd({rtx_pkg::OP_FREQ, 64'h0}, 5);
        cmd({rtx_pkg::OP_BASE, 16'h0040, 48'h0}, 3);
        cmd({rtx_pkg::OP_MOD, 64'h0}, 5);
        cmd({rtx_pkg::OP_FORMAT, 64'h0}, 2);
        cmd({rtx_pkg::OP_PINMAP, 16'h0243, 16'h0243, 32'h0}, 9);
        w_reg(16'h06C0, 8'h12);
        cmd({rtx_pkg::OP_RX, 24'hFFFFFF, 40'h0}, 4);
        pulse(1'b1, 1'b1, 8'h05);
        chk({mode, evt}, {rtx_pkg::RTX_RX, 3'b001});
        rd_flags;
        chk({rep[63:56], f}, {1'b0, rtx_pkg::MCODE_RX, 4'h0, 16'h0002});
        cmd({rtx_pkg::OP_CLRFLAGS, 16'h0002, 48'h0}, 3);
        cmd({rtx_pkg::OP_BUFINFO, 64'h0}, 4);
        chk(rep[55:40], 16'h0540);
        pulse(1'b1, 1'b0, 8'h03);
        rd_flags;
        chk(f, 16'h0042);
        cmd({rtx_pkg::OP_CLRFLAGS, 16'hFFFF, 48'h0}, 3);
        cmd({rtx_pkg::OP_STANDBY, 64'h0}, 2);
        cmd({rtx_pkg::OP_RX, 24'h00003C, 40'h0}, 4);
        negs(70);
        chk({mode, evt}, {rtx_pkg::RTX_STBY, 3'b001});
        rd_flags;
        chk(f, 16'h0200);
        cmd({rtx_pkg::OP_CLRFLAGS, 16'hFFFF, 48'h0}, 3);
    endtask
    task automatic t_implicit;
        cmd({rtx_pkg::OP_PROTOCOL, 8'h01, 56'h0}, 2);
        cmd({rtx_pkg::OP_MOD, 64'h0}, 5);
        cmd({rtx_pkg::OP_FORMAT, 8'h01, 56'h0}, 2);
        chk(cfg.implicit_hdr, 1'b1);
        cmd({rtx_pkg::OP_RX, 24'h000064, 40'h0}, 4);
        pulse(1'b1, 1'b1, 8'h04);
        chk(mode, rtx_pkg::RTX_STBY);
        negs(110);
        rd_flags;
        chk(f, 16'h0202);
        w_reg(rtx_pkg::ADDR_TMR_STOP, 8'h00);
        r_reg(rtx_pkg::ADDR_EVT_CLR);
        w_reg(rtx_pkg::ADDR_EVT_CLR, d | rtx_pkg::EVT_CLR_MASK);
        rd_flags;
        chk(f, 16'h0002);
        cmd({rtx_pkg::OP_CLRFLAGS, 16'hFFFF, 48'h0}, 3);
        // stopping the timer early must suppress the stale timeout
        cmd({rtx_pkg::OP_RX, 24'h000064, 40'h0}, 4);
        pulse(1'b1, 1'b1, 8'h04);
        w_reg(rtx_pkg::ADDR_TMR_STOP, 8'h00);
        negs(110);
        rd_flags;
        chk(f, 16'h0002);
    endtask

    ////////////////////////////////////////////////////////////////
    task automatic wrap_up;
        $display("checks %0d mismatches %0d", samples_checked, error_cnt);
        if (error_cnt == 0 && samples_checked > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask

    initial
    begin
        rst_b_i = 1'b0;
        tx_done = 1'b0;
        rx_pkt  = 1'b0;
        crc_ok  = 1'b0;
        rx_len  = 8'h00;
        repeat (16) @(posedge clock_i);
        @(negedge clock_i);
        t_reset;
        t_regs;
        t_tx;
        t_rx;
        t_implicit;
        wrap_up;
    end

    // whole run is near 0.12 ms; some twenty-five times that means a hang
    initial
    begin
        #3000000;
        error_cnt++;
        wrap_up;
    end
endmodule // testbench
